// File: cfs_host_model.sv
// host controller model that drives the two-wire register bus
`timescale 1ns/1ps
module cfs_host_model
  import cfs_pkg::*;
(
  // pacing clock
  input  wire logic clk_sys,
  // bus pins, sda_oe high pulls the data line low
  input  wire logic sda_in,
  output logic      scl,
  output logic      sda_oe
);
  logic odd = 1'b0;
  initial begin
    scl    = 1'b1;
    sda_oe = 1'b0;
  end
  // ----------------------------------------------------------------
  // bit level
  // ----------------------------------------------------------------
  // half of a 125 ns bus period: 12 and 13 system cycles in turn
  task automatic half();
    repeat (odd ? 13 : 12) @(negedge clk_sys);
    odd = ~odd;
  endtask : half
  // data changes only while the bus clock is low
  task automatic bit_io(input logic b, output logic s);
    sda_oe = ~b;
    half();
    scl = 1'b1;
    half();
    s = sda_in;
    scl = 1'b0;
  endtask : bit_io
  // one byte out, msb first, then a released ninth bit
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
    bit_io(1'b1, a);
    ack = ~a;
  endtask : xfer
  task automatic start();
    sda_oe = 1'b0;
    half();
    scl = 1'b1;
    half();
    sda_oe = 1'b1;
    half();
    scl = 1'b0;
  endtask : start
  task automatic stop();
    sda_oe = 1'b1;
    half();
    scl = 1'b1;
    half();
    sda_oe = 1'b0;
    half();
  endtask : stop
  // ----------------------------------------------------------------
  // register access
  // ----------------------------------------------------------------
  // callers keep limit codes at 18h or below and skip the test registers
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d, output logic ok);
    logic [7:0] r;
    logic       k1, k2, k3;
    start();
    xfer({CFS_DEV_ADDR, 1'b0}, r, k1);
    xfer(a, r, k2);
    xfer(d, r, k3);
    stop();
    ok = k1 & k2 & k3;
  endtask : wr_reg
  // read ends with a released ninth bit, which the device sees as a nack
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    logic [7:0] r;
    logic       k;
    start();
    xfer({CFS_DEV_ADDR, 1'b0}, r, k);
    xfer(a, r, k);
    start();
    xfer({CFS_DEV_ADDR, 1'b1}, r, k);
    xfer(8'hFF, d, k);
    stop();
  endtask : rd_reg
endmodule : cfs_host_model

// File: cfs_pkg.sv
// package: constants, register map and carrier types of the charger fault supervisor
package cfs_pkg;
  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] CFS_REG_MAIN  = 8'h00;
  localparam logic [7:0] CFS_REG_FUNC  = 8'h01;
  localparam logic [7:0] CFS_REG_SENSE = 8'h05;
  localparam logic [7:0] CFS_REG_STAT  = 8'h06;
  localparam logic [7:0] CFS_REG_TEST1 = 8'h07;
  localparam logic [7:0] CFS_REG_TEST2 = 8'h10;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CFS_MAIN_OVERVOLTAGE_LOCKOUT  = 7;
  localparam int CFS_MAIN_CONV  = 6;
  localparam int CFS_FUNC_TRKL  = 7;
  localparam int CFS_FUNC_WDT   = 4;
  localparam int CFS_FUNC_BAT   = 3;
  localparam int CFS_FUNC_MODE  = 0;
  localparam int CFS_SEL_MSB    = 7;
  localparam int CFS_SEL_LSB    = 6;
  localparam int CFS_LIM_MSB    = 4;
  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] CFS_MAIN_RST  = 8'hB1;
  localparam logic [7:0] CFS_FUNC_RST  = 8'hDC;
  localparam logic [7:0] CFS_SENSE_RST = 8'h00;
  localparam logic [7:0] CFS_TEST_RST  = 8'h00;
  localparam logic [6:0] CFS_DEV_ADDR  = 7'h2A;  // arbitrary bus address
  localparam logic [4:0] CFS_FEED_LIM  = 5'h18;  // fixed feed-mode threshold
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam longint CFS_CLK_HZ     = 200000000;
  localparam longint CFS_SAFETY_MIN = 36;
  localparam longint CFS_SAFETY_CYC = CFS_SAFETY_MIN * 60 * CFS_CLK_HZ;
  localparam longint CFS_WIN_MS     = 87;
  localparam longint CFS_WIN_CYC    = CFS_WIN_MS * CFS_CLK_HZ / 1000;
  localparam longint CFS_WDT_S      = 42;
  localparam longint CFS_WDT_CYC    = CFS_WDT_S * CFS_CLK_HZ;
  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic undervoltage_lockout;
    logic overvoltage_lockout;
    logic thermal_trip;
    logic cycle_current_limit;
    logic aux_low;
    logic aux_high;
    logic trickle_active;
    logic precharge_active;
    logic fastcharge_active;
    logic taper_active;
    logic charge_go;
    logic cycle_go;
  } cfs_sense_t;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
    logic       wr;
  } cfs_wr_t;
  typedef enum logic [2:0] {
    I_IDLE = 3'b000,
    I_ADDR = 3'b001,
    I_REG  = 3'b010,
    I_WDAT = 3'b011,
    I_ACK  = 3'b100,
    I_RDAT = 3'b101,
    I_RACK = 3'b110
  } cfs_i2c_t;
endpackage : cfs_pkg

// File: cfs_supervisor.sv
// module: charger fault supervisor with two-wire register slave
// Functional notes
// [RL1] sense selector: 00 output current, 01 battery/3, 10 supply/8; 11 forbidden
// [RL2] five-bit input limit code, 100 mA steps, 0 to 2400 mA
// [RL3] host never writes limit codes 11001 to 11111
// [RL4] limit used only in constant current; host programs with margin
// [RL5] status register is read-only; writes to it change nothing
// [RL6] status bits 7..4 show trickle, pre, fast, taper charge
// [RL7] status bits 3..0 show supply, thermal, battery, watchdog faults
// [RL8] fault bits clear when converter enable is written to one
// [RL9] host never accesses test registers 07h and 10h; both reset 00h
// [RL10] undervoltage turns converter off, state pin high, sets supply flag
// [RL11] overvoltage acts only when enabled; same shutdown and supply flag
// [RL12] thermal trip turns converter off, state pin high, sets thermal flag
// [RL13] fault flags hold until converter enable written one or reset
// [RL14] host restarts converter itself after a fault; no auto restart
// [RL15] high-side current at limit: high side off, low side on, per cycle
// [RL16] threshold from limit code in charge mode, fixed value in feed mode
// [RL17] battery check only in charge mode, when enabled, trickle in use
// [RL18] battery check arms only if aux sense low at charge start; code also arms it on an aux rise inside the taper window
// [RL19] safety timer runs through trickle; 36 minutes means battery missing
// [RL20] timer restarts if aux sense rises within 87 ms of taper entry
// [RL21] battery missing turns converter off, state pin high, sets flag
// [RL22] watchdog 42 s while enabled and on; acknowledge restarts it
// [RL23] converter enable is main control bit 6, reset off
// [RL24] state pin low while converter runs, high while off
// [RL25] function register: bit0 mode, bit4 watchdog, bit3 battery check
// [RL26] fault in same cycle as enable write wins; converter stays off
`timescale 1ns/1ps
module cfs_supervisor
  import cfs_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR      = CFS_DEV_ADDR,
  parameter logic [4:0] FEED_LIMIT    = CFS_FEED_LIM,
  parameter longint     SAFETY_CYCLES = CFS_SAFETY_CYC,
  parameter longint     WINDOW_CYCLES = CFS_WIN_CYC,
  parameter longint     WDT_CYCLES    = CFS_WDT_CYC
) (
  // clock, reset, enable
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic       ce,
  // two-wire register bus
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  // comparators and charge phase from the analog side
  input  wire cfs_sense_t cmp,
  // converter control
  output logic            converter_on,
  output logic            state_pin,
  output logic [1:0]      sense_out_select,
  output logic [4:0]      limit_code_out,
  output logic            hs_off_ls_on
);
  localparam logic [39:0] SAFE_M1 = 40'(SAFETY_CYCLES - 1);
  localparam logic [27:0] WIN_M1  = 28'(WINDOW_CYCLES - 1);
  localparam logic [35:0] WDT_M1  = 36'(WDT_CYCLES - 1);

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic [1:0] bus_m, bus_s, bus_p;  // {scl, sda}
  cfs_sense_t cmp_m, s, sp;
  // second stage feeds logic; first stage is read by nothing else
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      bus_m <= 2'h3;
      bus_s <= 2'h3;
      bus_p <= 2'h3;
      cmp_m <= '0;
      s     <= '0;
      sp    <= '0;
    end else if (ce) begin
      bus_m <= {scl_in, sda_in};
      bus_s <= bus_m;
      bus_p <= bus_s;
      cmp_m <= cmp;
      s     <= cmp_m;
      sp    <= s;
    end
  end

  logic scl_rise, scl_fall, start_ev, stop_ev, sda_s;
  assign sda_s    = bus_s[0];
  assign scl_rise = bus_s[1] & ~bus_p[1];
  assign scl_fall = ~bus_s[1] & bus_p[1];
  assign start_ev = bus_s[1] & bus_p[1] & bus_p[0] & ~bus_s[0];
  assign stop_ev  = bus_s[1] & bus_p[1] & ~bus_p[0] & bus_s[0];

  // ----------------------------------------------------------------
  // registers and read mux
  // ----------------------------------------------------------------
  logic [7:0] main_ctrl, func_ctrl, sense_cfg, rdata, ptr;
  logic [3:0] flags;  // supply, thermal, battery, watchdog
  cfs_wr_t    wr;

  // status has no storage of its own: phases are live, flags are latched
  always_comb begin
    unique case (ptr)
      CFS_REG_MAIN:  rdata = {main_ctrl[7], converter_on, main_ctrl[5:0]};
      CFS_REG_FUNC:  rdata = func_ctrl;
      CFS_REG_SENSE: rdata = sense_cfg;
      CFS_REG_STAT:  rdata = {s.trickle_active, s.precharge_active,  // see [RL6]
                             s.fastcharge_active, s.taper_active,
                             flags};                                // see [RL7]
      default:       rdata = CFS_TEST_RST;
    endcase
  end

  // writes to status and test offsets fall through and are dropped
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      main_ctrl <= CFS_MAIN_RST;
      func_ctrl <= CFS_FUNC_RST;
      sense_cfg <= CFS_SENSE_RST;
    end else if (ce && wr.wr) begin
      case (wr.addr)
        CFS_REG_MAIN:  main_ctrl <= wr.data;
        CFS_REG_FUNC:  func_ctrl <= wr.data;                        // see [RL25]
        CFS_REG_SENSE: sense_cfg <= wr.data;                        // see [RL1] [RL2]
        default:       ;                                            // see [RL5]
      endcase
    end
  end
  assign sense_out_select = sense_cfg[CFS_SEL_MSB:CFS_SEL_LSB];     // see [RL1]

  // ----------------------------------------------------------------
  // two-wire slave
  // ----------------------------------------------------------------
  cfs_i2c_t   st, back;
  logic [7:0] sh;
  logic [3:0] cnt;
  logic       rw, ack_pulse;

  // no auto-increment: repeated data bytes hit the same pointer
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st <= I_IDLE;
      back <= I_IDLE;
      sh <= 8'h00;
      cnt <= 4'h0;
      ptr <= 8'h00;
      rw <= 1'h0;
      sda_oe <= 1'h0;
      wr <= '0;
      ack_pulse <= 1'h0;
    end else if (ce) begin
      wr.wr <= 1'h0;
      ack_pulse <= 1'h0;
      if (start_ev) begin
        st <= I_ADDR;
        cnt <= 4'h0;
        sda_oe <= 1'h0;
      end else if (stop_ev) begin
        st <= I_IDLE;
        sda_oe <= 1'h0;
      end else if (scl_rise) begin
        unique case (st)
          I_ADDR, I_REG, I_WDAT: begin
            sh <= {sh[6:0], sda_s};
            cnt <= cnt + 4'h1;
          end
          I_RDAT: begin
            sh <= {sh[6:0], 1'h0};
            cnt <= cnt + 4'h1;
          end
          I_RACK: begin
            if (sda_s) begin
              st <= I_IDLE;  // master refused: end of read
            end else begin
              sh <= rdata;
              cnt <= 4'h0;
              st <= I_RDAT;
            end
          end
          default: ;
        endcase
      end else if (scl_fall) begin
        unique case (st)
          I_ADDR: if (cnt == 4'h8) begin
            if (sh[7:1] == DEV_ADDR) begin
              rw <= sh[0];
              sda_oe <= 1'h1;
              ack_pulse <= 1'h1;
              back <= I_ADDR;
              st <= I_ACK;
            end else begin
              st <= I_IDLE;
            end
          end
          I_REG: if (cnt == 4'h8) begin
            ptr <= sh;
            sda_oe <= 1'h1;
            ack_pulse <= 1'h1;
            back <= I_REG;
            st <= I_ACK;
          end
          I_WDAT: if (cnt == 4'h8) begin
            wr <= '{addr: ptr, data: sh, wr: 1'h1};
            sda_oe <= 1'h1;
            ack_pulse <= 1'h1;
            back <= I_WDAT;
            st <= I_ACK;
          end
          I_ACK: begin
            cnt <= 4'h0;
            if (back == I_ADDR && rw) begin
              sh <= rdata;
              sda_oe <= ~rdata[7];
              st <= I_RDAT;
            end else begin
              sda_oe <= 1'h0;
              st <= (back == I_ADDR) ? I_REG : I_WDAT;
            end
          end
          I_RDAT: begin
            if (cnt == 4'h8) begin
              sda_oe <= 1'h0;
              st <= I_RACK;
            end else begin
              sda_oe <= ~sh[7];
            end
          end
          default: ;
        endcase
      end
    end
  end
  // open drain: the line is only ever pulled low
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) sda_out <= 1'h0;
    else if (ce) sda_out <= 1'h0;
  end

  // ----------------------------------------------------------------
  // watchdog
  // ----------------------------------------------------------------
  logic [35:0] wdt_cnt;
  logic        wdt_run, wdt_ev;
  assign wdt_run = func_ctrl[CFS_FUNC_WDT] & converter_on;
  assign wdt_ev  = wdt_run & ~ack_pulse & (wdt_cnt == WDT_M1);      // see [RL22]
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) wdt_cnt <= '0;
    else if (ce) begin
      if (!wdt_run || ack_pulse || wdt_ev) wdt_cnt <= '0;           // see [RL22]
      else wdt_cnt <= wdt_cnt + 36'h1;
    end
  end

  // ----------------------------------------------------------------
  // battery-missing safety timer
  // ----------------------------------------------------------------
  logic [39:0] bat_cnt;
  logic [27:0] win_cnt;
  logic        bat_ok, bat_armed, second, win_open, bat_run, bat_ev;
  assign bat_ok  = func_ctrl[CFS_FUNC_BAT] & ~func_ctrl[CFS_FUNC_MODE]
                 & func_ctrl[CFS_FUNC_TRKL];                        // see [RL17]
  assign bat_run = bat_ok & bat_armed & converter_on & (s.trickle_active | second);
  assign bat_ev  = bat_run & (bat_cnt == SAFE_M1);                  // see [RL19]
  // second pass keeps counting after taper entry until the limit
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      bat_cnt <= '0;
      win_cnt <= '0;
      bat_armed <= 1'h0;
      second <= 1'h0;
      win_open <= 1'h0;
    end else if (ce) begin
      if (s.taper_active && !sp.taper_active) begin
        win_open <= 1'h1;
        win_cnt <= '0;
      end else if (win_open) begin
        win_open <= (win_cnt != WIN_M1);
        win_cnt <= win_cnt + 28'h1;
      end
      if (!bat_ok || bat_ev) begin
        bat_armed <= 1'h0;
        second <= 1'h0;
      end else if (s.charge_go && !sp.charge_go) begin
        bat_armed <= s.aux_low;                                     // see [RL18]
        second <= 1'h0;
        bat_cnt <= '0;                                              // see [RL19]
      end else if (win_open && s.aux_high && !sp.aux_high) begin
        bat_armed <= 1'h1;                                          // see [RL20]
        second <= 1'h1;
        bat_cnt <= '0;
      end else if (bat_run) begin
        bat_cnt <= bat_cnt + 40'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // fault latching and converter enable
  // ----------------------------------------------------------------
  logic [3:0] set_vec, next_flags;
  logic       clr_req, main_wr, next_on;
  assign set_vec = {s.undervoltage_lockout                          // see [RL10]
                    | (s.overvoltage_lockout & main_ctrl[CFS_MAIN_OVERVOLTAGE_LOCKOUT]), // see [RL11]
                    s.thermal_trip,                                 // see [RL12]
                    bat_ev,                                         // see [RL21]
                    wdt_ev};                                        // see [RL22]
  assign main_wr = wr.wr & (wr.addr == CFS_REG_MAIN);
  assign clr_req = main_wr & wr.data[CFS_MAIN_CONV];
  // a new fault is ORed in after the clear so it is never lost
  assign next_flags = set_vec | (clr_req ? 4'h0 : flags);           // see [RL8] [RL13]
  assign next_on = (|set_vec) ? 1'h0 :                              // see [RL26]
                   main_wr ? wr.data[CFS_MAIN_CONV] : converter_on; // see [RL23]
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      flags <= 4'h0;
      converter_on <= 1'h0;
      state_pin <= 1'h1;
    end else if (ce) begin
      flags <= next_flags;
      converter_on <= next_on;
      state_pin <= ~next_on;                                        // see [RL24]
    end
  end

  // ----------------------------------------------------------------
  // cycle-by-cycle current limit
  // ----------------------------------------------------------------
  // a trip holds only until the next switching cycle begins
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      hs_off_ls_on <= 1'h0;
      limit_code_out <= 5'h00;
    end else if (ce) begin
      if (s.cycle_current_limit) hs_off_ls_on <= 1'h1;              // see [RL15]
      else if (s.cycle_go && !sp.cycle_go) hs_off_ls_on <= 1'h0;
      limit_code_out <= func_ctrl[CFS_FUNC_MODE] ? FEED_LIMIT       // see [RL16]
                        : sense_cfg[CFS_LIM_MSB:0];
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  sequence q_write_on;
    ce && clr_req;
  endsequence
  sequence q_quiet;
    !(|set_vec);
  endsequence
  AST_STATE_PIN: assert property (state_pin == !converter_on)       // see [RL24]
    else $error("state pin disagrees with converter enable");
  AST_UV_OFF: assert property (ce && s.undervoltage_lockout         // see [RL10]
    |=> !converter_on && flags[3]) else $error("undervoltage not latched");
  AST_OV_ON: assert property (ce && s.overvoltage_lockout &&        // see [RL11]
    main_ctrl[CFS_MAIN_OVERVOLTAGE_LOCKOUT] |=> !converter_on && flags[3])
    else $error("overvoltage not latched");
  AST_HOT: assert property (ce && s.thermal_trip                    // see [RL12]
    |=> !converter_on && state_pin && flags[2]) else $error("thermal trip missed");
  AST_HOLD: assert property (ce && !clr_req                         // see [RL13]
    |=> (flags & $past(flags)) == $past(flags)) else $error("flag dropped");
  AST_CLEAR: assert property ((q_write_on and q_quiet)              // see [RL8]
    |=> flags == 4'h0 && converter_on) else $error("enable write did not clear");
  AST_PRIO: assert property (q_write_on ##0 (|set_vec)              // see [RL26]
    |=> !converter_on && flags != 4'h0) else $error("fault lost to enable write");
  AST_OCL: assert property (ce && s.cycle_current_limit             // see [RL15]
    |=> hs_off_ls_on) else $error("current limit ignored");
  AST_LIMIT: assert property (ce ##1 ce |-> limit_code_out ==       // see [RL16]
    ($past(func_ctrl[CFS_FUNC_MODE]) ? FEED_LIMIT : $past(sense_cfg[CFS_LIM_MSB:0])))
    else $error("wrong current threshold");
  AST_WDT: assert property (ce && wdt_run && !ack_pulse &&          // see [RL22]
    wdt_cnt == WDT_M1 |=> flags[0] && !converter_on) else $error("watchdog missed");
  AST_BAT_GATE: assert property (ce && !bat_ok && !flags[1]         // see [RL17]
    |=> !flags[1]) else $error("battery check out of mode");
endmodule : cfs_supervisor

// File: cfs_supervisor_test.sv
// self-checking bench of the charger fault supervisor
`timescale 1ns/1ps
module cfs_supervisor_test import cfs_pkg::*;;
  typedef struct packed {logic [7:0] cfg; logic [3:0] ph;} cfs_row_t;
  cfs_row_t   rows [5] = '{'{8'h00, 4'h8}, '{8'h40, 4'h4}, '{8'h80, 4'h2},
                           '{8'h18, 4'h1}, '{8'h57, 4'h0}};
  logic [11:0] fm [3]  = '{12'h800, 12'h400, 12'h200};
  logic [7:0]  ff [3]  = '{8'h08, 8'h08, 8'h04};
  logic        clk_sys, rst, ce, scl, host_oe, sda_oe, sda_out, ok;
  logic        converter_on, state_pin, hs_off_ls_on;
  logic [1:0]  sense_out_select;
  logic [4:0]  limit_code_out;
  logic [7:0]  rd;
  cfs_sense_t  cmp;
  int          err_count = 0;
  int          checks    = 0;
  int          cyc       = 0;
  // open-drain data line with pull-up
  wire sda_line = ~(host_oe | (sda_oe & ~sda_out));
  cfs_supervisor #(.SAFETY_CYCLES(200), .WINDOW_CYCLES(50), .WDT_CYCLES(2000)) dut_u (
    .clk_sys(clk_sys), .rst(rst), .ce(ce), .scl_in(scl), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe(sda_oe), .cmp(cmp), .converter_on(converter_on),
    .state_pin(state_pin), .sense_out_select(sense_out_select),
    .limit_code_out(limit_code_out), .hs_off_ls_on(hs_off_ls_on));
  cfs_host_model host_u (.clk_sys(clk_sys), .sda_in(sda_line), .scl(scl), .sda_oe(host_oe));
  initial clk_sys = 1'b0;
  always #2.5 clk_sys = ~clk_sys;
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic test_done();
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : test_done
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host_u.wr_reg(a, d, ok);
    chk(ok, 1'b1);
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    host_u.rd_reg(a, rd);
    chk(rd, exp);
  endtask : rdc
  // comparators move on a falling edge, then settle through the synchronisers
  task automatic setc(input logic [11:0] m);
    @(negedge clk_sys);
    cmp = cfs_sense_t'(m);
    repeat (10) @(negedge clk_sys);
  endtask : setc
  // hang guard, well above the expected run length
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 80000) begin
      err_count++;
      test_done();
    end
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    rst = 1'b1;
    ce  = 1'b1;
    cmp = '0;
    repeat (16) @(negedge clk_sys);
    rst = 1'b0;
    repeat (4) @(negedge clk_sys);
    chk(converter_on, 1'b0);
    chk(state_pin, 1'b1);
    chk(limit_code_out, 5'h00);
    chk(sda_out, 1'b0); // open drain: only ever pulls low
    rdc(CFS_REG_MAIN, CFS_MAIN_RST);
    rdc(CFS_REG_FUNC, CFS_FUNC_RST);
    rdc(CFS_REG_STAT, 8'h00);
    // selector codes, limit boundaries and live charge phases
    foreach (rows[i]) begin
      setc({6'h00, rows[i].ph, 2'b00});
      wr(CFS_REG_SENSE, rows[i].cfg);
      repeat (3) @(negedge clk_sys);
      chk(sense_out_select, rows[i].cfg[7:6]);
      chk(limit_code_out, rows[i].cfg[4:0]);
      rdc(CFS_REG_SENSE, rows[i].cfg);
      rdc(CFS_REG_STAT, {rows[i].ph, 4'h0});
    end
    setc(12'h000);
    // feed mode swaps in the fixed threshold
    wr(CFS_REG_FUNC, 8'hDD);
    repeat (3) @(negedge clk_sys);
    chk(limit_code_out, CFS_FEED_LIM);
    wr(CFS_REG_FUNC, 8'hCC);
    // writes to status and to an unmapped offset leave everything alone
    wr(CFS_REG_STAT, 8'hFF);
    wr(8'h20, 8'h00);
    rdc(CFS_REG_STAT, 8'h00);
    rdc(CFS_REG_SENSE, 8'h57);
    // latched faults: supply low, supply high, thermal
    for (int i = 0; i < 3; i++) begin
      wr(CFS_REG_MAIN, 8'hF1); // host restart
      chk(converter_on, 1'b1);
      chk(state_pin, 1'b0);
      setc(fm[i]);
      setc(12'h000);
      chk(converter_on, 1'b0);
      chk(state_pin, 1'b1);
      rdc(CFS_REG_STAT, ff[i]);
      wr(CFS_REG_MAIN, 8'hF1);
      rdc(CFS_REG_STAT, 8'h00);
    end
    // a frozen enable holds off a fault; a fault held through an enable write wins
    ce = 1'b0;
    setc(12'h200);
    chk(converter_on, 1'b1); // clock enable freezes all state
    ce = 1'b1;
    setc(12'h200);
    chk(converter_on, 1'b0);
    wr(CFS_REG_MAIN, 8'hF1);
    chk(converter_on, 1'b0);
    rdc(CFS_REG_STAT, 8'h04);
    setc(12'h000);
    // overvoltage ignored while its enable is off
    wr(CFS_REG_MAIN, 8'h71);
    setc(12'h400);
    setc(12'h000);
    chk(converter_on, 1'b1);
    // per-cycle current limit, cleared only by the next cycle start
    setc(12'h100);
    chk(hs_off_ls_on, 1'b1);
    setc(12'h000);
    chk(hs_off_ls_on, 1'b1);
    setc(12'h001);
    chk(hs_off_ls_on, 1'b0);
    // battery check: no arming without aux low at charge start
    setc(12'h020);
    setc(12'h022);
    repeat (250) @(negedge clk_sys);
    chk(converter_on, 1'b1);
    setc(12'h0A0);
    setc(12'h0A2);
    repeat (250) @(negedge clk_sys);
    chk(converter_on, 1'b0);
    chk(state_pin, 1'b1);
    rdc(CFS_REG_STAT, 8'h82);
    setc(12'h000);
    wr(CFS_REG_MAIN, 8'hF1);
    // second check: only an aux rise inside the taper window restarts the timer
    for (int i = 0; i < 2; i++) begin
      setc(12'h0A0);
      setc(12'h0A2);
      setc(12'h004);
      repeat (i ? 0 : 60) @(negedge clk_sys);
      setc(12'h044);
      repeat (250) @(negedge clk_sys);
      chk(converter_on, (i == 0));
      if (i == 1) rdc(CFS_REG_STAT, 8'h12);
      setc(12'h000);
      wr(CFS_REG_MAIN, 8'hF1);
    end
    // watchdog: an acknowledge restarts it, a quiet bus lets it expire
    wr(CFS_REG_FUNC, 8'hDC);
    repeat (1500) @(negedge clk_sys);
    chk(converter_on, 1'b1);
    rdc(CFS_REG_FUNC, 8'hDC);
    repeat (1500) @(negedge clk_sys);
    chk(converter_on, 1'b1);
    repeat (600) @(negedge clk_sys);
    chk(converter_on, 1'b0);
    rdc(CFS_REG_STAT, 8'h01);
    // reset in mid-run clears the flag
    rst = 1'b1;
    repeat (4) @(negedge clk_sys);
    rst = 1'b0;
    repeat (4) @(negedge clk_sys);
    chk(state_pin, 1'b1);
    rdc(CFS_REG_STAT, 8'h00);
    test_done();
  end
endmodule : cfs_supervisor_test
